// File: core/udc_pkg.sv
/*
 * Constants, register map and carrier types of the USB and DDR clock
 * source selection block.
 * Assumes one 10 MHz system clock; every incoming clock is a level
 * sampled synchronously to it.
 */
package udc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_REFFREQ = 12'h004;
    localparam logic [11:0] OFS_STATUS  = 12'h008;

    localparam int CTRL_W       = 5;
    localparam int REFFREQ_W    = 4;
    localparam logic [3:0] REFFREQ_MAX = 4'h8;
    localparam logic [3:0] REFFREQ_RST = 4'h0;

    // ------------------------------------------------------------------
    // Divider half periods, in source rising edges
    // ------------------------------------------------------------------
    localparam int HALF_DIV2 = 1;
    localparam int HALF_DIV4 = 2;

    // Reference frequency codes for the HS PHY PLL
    typedef enum logic [3:0] {
        REF_12M   = 4'h0,
        REF_24M   = 4'h1,
        REF_48M   = 4'h2,
        REF_19M2  = 4'h3,
        REF_38M4  = 4'h4,
        REF_13M   = 4'h5,
        REF_26M   = 4'h6,
        REF_20M   = 4'h7,
        REF_40M   = 4'h8
    } udc_ref_t;

    typedef struct packed {
        logic memBusGate;
        logic ddrSrcSel;
        logic hsPhyPllKeepOn;
        logic fsClk48Select;
        logic hsRefclkSelect;
    } udc_ctrl_t;

    localparam udc_ctrl_t CTRL_RST = '{default: 1'b0};

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } udc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } udc_apb_rsp_t;

endpackage

// File: core/udc_glitch_mux.sv
/*
 * Two-input clock source mux that never cuts a pulse short.
 * Assumes both sources are levels sampled on clk_sys.
 */
module udc_glitch_mux
    import udc_pkg::*;
(
    input  wire logic clk_sys,   // System clock
    input  wire logic rst_n,     // Async reset
    input  wire logic ce,        // Clock enable
    input  wire logic srcZero,   // Source for select 0
    input  wire logic srcOne,    // Source for select 1
    input  wire logic sel,       // Requested source
    output logic      clkOut,    // Muxed clock
    output logic      selNow     // Source in use
);
    logic gate_r, gate_nxt, sel_r, sel_nxt, out_r, out_nxt;
    logic curSrc, nxtSrc;

    always_comb begin
        curSrc   = sel_r ? srcOne : srcZero;
        sel_nxt  = sel_r;
        gate_nxt = gate_r;
        // Gate only moves while the source in use is low; select only moves while the gate is closed
        if (gate_r && sel != sel_r && !curSrc) begin
            gate_nxt = 1'b0;
        end else if (!gate_r && sel != sel_r) begin
            sel_nxt = sel;
        end else if (!gate_r && !curSrc) begin
            gate_nxt = 1'b1;
        end
        nxtSrc  = sel_nxt ? srcOne : srcZero;
        out_nxt = gate_nxt & nxtSrc;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate_r <= 1'b0;
            sel_r  <= 1'b0;
            out_r  <= 1'b0;
        end else if (ce) begin
            gate_r <= gate_nxt;
            sel_r  <= sel_nxt;
            out_r  <= out_nxt;
        end
    end

    assign clkOut = out_r;
    assign selNow = sel_r;

    a_mux_gate_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(gate_r) |-> !$past(curSrc))
        else $error("mux gate moved while source high");
    a_mux_out_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && gate_r && sel == sel_r |=>
        out_r == $past(curSrc))
        else $error("mux output does not follow source");

endmodule // udc_glitch_mux

// File: core/udc_clk_div.sv
/*
 * Clock divider on sampled clock levels: toggles every HALF rising edges.
 * Assumes the source is a level sampled on clk_sys.
 */
module udc_clk_div
    import udc_pkg::*;
#(
    parameter int HALF = HALF_DIV2
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst_n,     // Async reset
    input  wire logic ce,        // Clock enable
    input  wire logic clkIn,     // Source clock level
    output logic      clkOut     // Divided clock
);
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    // Elaboration-time refusal of a divider that cannot count
    if (HALF < 1) begin : g_bad_half
        $error("udc_clk_div: HALF must be at least 1");
    end

    logic prev_r, prev_nxt, out_r, out_nxt, rise;
    logic [CW-1:0] cnt_r, cnt_nxt;

    always_comb begin
        rise     = clkIn & ~prev_r;
        prev_nxt = clkIn;
        cnt_nxt  = cnt_r;
        out_nxt  = out_r;
        if (rise) begin
            if (cnt_r == LAST) begin
                cnt_nxt = '0;
                out_nxt = ~out_r;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            cnt_r  <= '0;
            out_r  <= 1'b0;
        end else if (ce) begin
            prev_r <= prev_nxt;
            cnt_r  <= cnt_nxt;
            out_r  <= out_nxt;
        end
    end

    assign clkOut = out_r;

    a_div_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && rise && cnt_r == LAST |=> out_r != $past(out_r))
        else $error("divider missed its toggle");
    a_div_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && !(rise && cnt_r == LAST) |=> out_r == $past(out_r))
        else $error("divider toggled early");

endmodule // udc_clk_div

// File: core/udc_top.sv
/*
 * USB and DDR clock source selection: source muxes, dividers, suspend
 * keep-on control and APB control registers.
 * Assumes all incoming clocks are levels synchronous to clk_sys and an
 * APB master that holds each request until pready.
 */
// Decided for this implementation: the register addresses and the APB register port.
module udc_top
    import udc_pkg::*;
(
    input  wire logic                  clk_sys,          // 10 MHz clock
    input  wire logic                  rst_n,            // Async reset
    input  wire logic                  ce,               // Clock enable
    input  wire udc_pkg::udc_apb_req_t apbReq,           // APB request
    output udc_pkg::udc_apb_rsp_t      apbRsp,           // APB answer
    input  wire logic                  usbRefClockPin,   // Reference pin
    input  wire logic                  pllAuxClock,      // PLL aux clock
    input  wire logic                  hsPhyClk48,       // PHY 48 MHz out
    input  wire logic                  sysClockHalfCpu,  // CPU/2 clock
    input  wire logic                  sysClockQuarterCpu, // CPU/4 clock
    input  wire logic                  secondPllOutOne,  // PLL2 divided
    input  wire logic                  secondPllDirect,  // PLL2 direct
    input  wire logic                  usbSuspend,       // USB suspended
    output logic                       hsPhyRefClk,      // PHY reference
    output logic [3:0]                 hsPhyRefFreq,     // PHY PLL code
    output logic                       hsPhyKeep48,      // PHY keep 48M
    output logic                       hsBusClk,         // HS bus clock
    output logic                       fsClock48m,       // FS 48 MHz
    output logic                       fsClock12m,       // FS 12 MHz
    output logic                       fsBusClk,         // FS bus clock
    output logic                       memBusClock,      // Memory bus clk
    output logic                       memDoubleClock,   // Double rate
    output logic                       memCoreClock,     // Core clock
    output logic                       memClkTrue,       // Memory clk
    output logic                       memClkComp        // Its complement
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    udc_ctrl_t      ctrl_r, ctrl_nxt;
    logic [3:0]     refFreq_r, refFreq_nxt;
    udc_apb_rsp_t   rsp_r, rsp_nxt;

    logic           hsMux, fsMux, ddrMux;
    logic           hsSelNow, fsSelNow, ddrSelNow;
    logic           fs12Div, busDiv, coreDiv;
    logic           setup, wrHit, rdErr;

    function automatic logic addrKnown(input logic [11:0] a);
        addrKnown = (a == OFS_CTRL) || (a == OFS_REFFREQ) ||
                    (a == OFS_STATUS);
    endfunction

    function automatic logic refCodeOk(input logic [3:0] c);
        refCodeOk = (c <= REFFREQ_MAX);
    endfunction

    // ------------------------------------------------------------------
    // APB slave, zero wait: answer in the access cycle
    // ------------------------------------------------------------------
    always_comb begin
        setup       = apbReq.psel && !apbReq.penable;
        wrHit       = setup && apbReq.pwrite;
        rdErr       = !addrKnown(apbReq.paddr);
        ctrl_nxt    = ctrl_r;
        refFreq_nxt = refFreq_r;
        rsp_nxt     = '{prdata: 32'h0000_0000, pready: 1'b0,
                        pslverr: 1'b0};
        if (setup) begin
            rsp_nxt.pready  = 1'b1;
            rsp_nxt.pslverr = rdErr;
            if (!apbReq.pwrite) begin
                case (apbReq.paddr)
                    OFS_CTRL: begin
                        rsp_nxt.prdata[CTRL_W-1:0] = ctrl_r;
                    end
                    OFS_REFFREQ: begin
                        rsp_nxt.prdata[REFFREQ_W-1:0] = refFreq_r;
                    end
                    OFS_STATUS: begin
                        rsp_nxt.prdata[5:0] = {hsPhyKeep48, usbSuspend,
                                               1'b0, ddrSelNow,
                                               fsSelNow, hsSelNow};
                    end
                    default: begin
                        rsp_nxt.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        if (wrHit) begin
            case (apbReq.paddr)
                OFS_CTRL: begin
                    ctrl_nxt = apbReq.pwdata[CTRL_W-1:0];
                end
                OFS_REFFREQ: begin
                    // Unsupported codes leave the PHY setting alone
                    if (refCodeOk(apbReq.pwdata[REFFREQ_W-1:0])) begin
                        refFreq_nxt = apbReq.pwdata[REFFREQ_W-1:0];
                    end
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r    <= CTRL_RST;
            refFreq_r <= REFFREQ_RST;
            rsp_r     <= '{prdata: 32'h0000_0000, pready: 1'b0,
                           pslverr: 1'b0};
        end else if (ce) begin
            ctrl_r    <= ctrl_nxt;
            refFreq_r <= refFreq_nxt;
            rsp_r     <= rsp_nxt;
        end
    end

    assign apbRsp       = rsp_r;
    assign hsPhyRefFreq = refFreq_r;

    // ------------------------------------------------------------------
    // USB source muxes and 12 MHz divider
    // ------------------------------------------------------------------
    udc_glitch_mux u_hsRefMux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .srcZero (usbRefClockPin),
        .srcOne  (pllAuxClock),
        .sel     (ctrl_r.hsRefclkSelect),
        .clkOut  (hsMux),
        .selNow  (hsSelNow)
    );

    // Pin source relies on the pin carrying exactly 48 MHz
    udc_glitch_mux u_fs48Mux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .srcZero (hsPhyClk48),
        .srcOne  (usbRefClockPin),
        .sel     (ctrl_r.fsClk48Select),
        .clkOut  (fsMux),
        .selNow  (fsSelNow)
    );

    udc_clk_div #(.HALF(HALF_DIV4)) u_fs12Div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .clkIn   (fsMux),
        .clkOut  (fs12Div)
    );

    // ------------------------------------------------------------------
    // Memory clock path
    // ------------------------------------------------------------------
    udc_glitch_mux u_ddrMux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .srcZero (secondPllDirect),
        .srcOne  (secondPllOutOne),
        .sel     (ctrl_r.ddrSrcSel),
        .clkOut  (ddrMux),
        .selNow  (ddrSelNow)
    );

    udc_clk_div #(.HALF(HALF_DIV2)) u_busDiv (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .clkIn   (sysClockHalfCpu),
        .clkOut  (busDiv)
    );

    // Core clock feeds controller state machine and registers
    udc_clk_div #(.HALF(HALF_DIV2)) u_coreDiv (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .clkIn   (ddrMux),
        .clkOut  (coreDiv)
    );

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    logic busGate_r, busGate_nxt;
    logic keep_r, keep_nxt;
    logic hsRef_r, hsRef_nxt, hsBus_r, hsBus_nxt;
    logic fs48_r, fs48_nxt, fs12_r, fs12_nxt, fsBus_r, fsBus_nxt;
    logic memBus_r, memBus_nxt, memDbl_r, memDbl_nxt;
    logic memCore_r, memCore_nxt, memT_r, memT_nxt, memC_r, memC_nxt;

    always_comb begin
        // Bus clock gate only moves while the divided clock is low
        busGate_nxt = busGate_r;
        if (!busDiv) begin
            busGate_nxt = ctrl_r.memBusGate;
        end
        // Keep-on forces the PHY 48 MHz on; else run unless suspended
        keep_nxt    = ctrl_r.hsPhyPllKeepOn || !usbSuspend;
        hsRef_nxt   = hsMux;
        hsBus_nxt   = sysClockHalfCpu;
        fs48_nxt    = fsMux;
        fs12_nxt    = fs12Div;
        fsBus_nxt   = sysClockQuarterCpu;
        memBus_nxt  = busDiv & ~busGate_nxt;
        memDbl_nxt  = ddrMux;
        memCore_nxt = coreDiv;
        // Memory pins follow the core clock divider, never the bus gate
        memT_nxt    = coreDiv;
        memC_nxt    = ~coreDiv;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busGate_r <= 1'b0;
            keep_r    <= 1'b1;
            hsRef_r   <= 1'b0;
            hsBus_r   <= 1'b0;
            fs48_r    <= 1'b0;
            fs12_r    <= 1'b0;
            fsBus_r   <= 1'b0;
            memBus_r  <= 1'b0;
            memDbl_r  <= 1'b0;
            memCore_r <= 1'b0;
            memT_r    <= 1'b0;
            memC_r    <= 1'b1;
        end else if (ce) begin
            busGate_r <= busGate_nxt;
            keep_r    <= keep_nxt;
            hsRef_r   <= hsRef_nxt;
            hsBus_r   <= hsBus_nxt;
            fs48_r    <= fs48_nxt;
            fs12_r    <= fs12_nxt;
            fsBus_r   <= fsBus_nxt;
            memBus_r  <= memBus_nxt;
            memDbl_r  <= memDbl_nxt;
            memCore_r <= memCore_nxt;
            memT_r    <= memT_nxt;
            memC_r    <= memC_nxt;
        end
    end

    assign hsPhyKeep48    = keep_r;
    assign hsPhyRefClk    = hsRef_r;
    assign hsBusClk       = hsBus_r;
    assign fsClock48m     = fs48_r;
    assign fsClock12m     = fs12_r;
    assign fsBusClk       = fsBus_r;
    assign memBusClock    = memBus_r;
    assign memDoubleClock = memDbl_r;
    assign memCoreClock   = memCore_r;
    assign memClkTrue     = memT_r;
    assign memClkComp     = memC_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_keep_on_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && ctrl_r.hsPhyPllKeepOn |=> hsPhyKeep48)
        else $error("PHY 48 MHz not held on by keep-on");
    a_suspend_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && !ctrl_r.hsPhyPllKeepOn && usbSuspend |=> !hsPhyKeep48)
        else $error("PHY 48 MHz kept on in suspend without keep-on");
    a_hs_bus_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce |=> hsBusClk == $past(sysClockHalfCpu))
        else $error("HS bus clock not from half-CPU clock");
    a_fs_bus_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce |=> fsBusClk == $past(sysClockQuarterCpu))
        else $error("FS bus clock not from quarter-CPU clock");
    a_ref_code_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && wrHit && apbReq.paddr == OFS_REFFREQ &&
        apbReq.pwdata[3:0] > REFFREQ_MAX |=> $stable(refFreq_r))
        else $error("unsupported reference code accepted");
    a_mem_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        memClkComp == !memClkTrue)
        else $error("memory clock pair not complementary");
    a_mem_ungated: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && busGate_r ##1 ce |-> memClkTrue == $past(coreDiv))
        else $error("memory clock lost while bus clock gated");
    a_bus_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && busGate_r && ctrl_r.memBusGate |=> !memBusClock)
        else $error("memory bus clock runs while gated");
    a_hs_ref_sel: assert property (@(posedge clk_sys)
        disable iff (!rst_n || !ce)
        hsSelNow != ctrl_r.hsRefclkSelect |-> ##[1:16]
        hsSelNow == ctrl_r.hsRefclkSelect)
        else $error("HS reference select not applied");
    a_fs_sel_settle: assert property (@(posedge clk_sys)
        disable iff (!rst_n || !ce)
        fsSelNow != ctrl_r.fsClk48Select |-> ##[1:16]
        fsSelNow == ctrl_r.fsClk48Select)
        else $error("FS 48 MHz select did not settle");
    a_apb_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && setup |=> apbRsp.pready && apbRsp.pslverr == $past(rdErr))
        else $error("APB answer missing in access cycle");

endmodule // udc_top

// File: bench/udc_src_model.sv
/*
 * Source clock model: free-running clock levels for the block's inputs, except phy48, which stops in suspend without keep.
 * Assumes clk_sys as time base; level i toggles every HP[i] cycles.
 */
module udc_src_model (
    input  wire logic  clk_sys,     // System clock
    input  wire logic  rst_n,       // Async reset
    input  wire logic  usbSuspend,  // USB suspended
    input  wire logic  hsPhyKeep48, // PHY keep request
    output logic [6:0] srcClk       // ref,aux,phy48,half,qtr,one,direct
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HP [7] = '{1, 3, 2, 2, 4, 3, 1};
    int age [7];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srcClk <= '0;
            age <= '{default: 0};
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (i == 2 && usbSuspend && !hsPhyKeep48) begin
                    // Stopped PHY clock rests low
                    srcClk[i] <= 1'b0;
                    age[i] <= 0;
                end else if (age[i] == HP[i] - 1) begin
                    srcClk[i] <= ~srcClk[i];
                    age[i] <= 0;
                end else begin
                    age[i] <= age[i] + 1;
                end
            end
        end
    end
endmodule // udc_src_model

// File: bench/testbench.sv
/*
 * Register-level test of the clock source block: APB tasks and edge
 * counts of every clock output but memClkComp over a fixed window.
 * Assumes udc_src_model rates; zero-wait APB answer per hand-over.
 */
module testbench;
    import udc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 240;
    logic         clk_sys = 1'b0;
    logic         rst_n, ce, usbSuspend;
    udc_apb_req_t apbReq;
    udc_apb_rsp_t apbRsp;
    logic [6:0]   srcClk;
    logic [3:0]   hsPhyRefFreq;
    logic         hsPhyRefClk, hsPhyKeep48, hsBusClk, fsClock48m;
    logic         fsClock12m, fsBusClk, memBusClock, memDoubleClock;
    logic         memCoreClock, memClkTrue, memClkComp;
    logic [8:0]   mon, monPrev;
    int           cnt [9];
    int           err_total = 0, n_tests = 0, cyc = 0;

    udc_src_model src_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .usbSuspend(usbSuspend), .hsPhyKeep48(hsPhyKeep48), .srcClk(srcClk));
    udc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .apbReq(apbReq), .apbRsp(apbRsp), .usbRefClockPin(srcClk[0]),
        .pllAuxClock(srcClk[1]), .hsPhyClk48(srcClk[2]),
        .sysClockHalfCpu(srcClk[3]), .sysClockQuarterCpu(srcClk[4]),
        .secondPllOutOne(srcClk[5]), .secondPllDirect(srcClk[6]),
        .usbSuspend(usbSuspend), .hsPhyRefClk(hsPhyRefClk),
        .hsPhyRefFreq(hsPhyRefFreq), .hsPhyKeep48(hsPhyKeep48),
        .hsBusClk(hsBusClk), .fsClock48m(fsClock48m),
        .fsClock12m(fsClock12m), .fsBusClk(fsBusClk),
        .memBusClock(memBusClock), .memDoubleClock(memDoubleClock),
        .memCoreClock(memCoreClock), .memClkTrue(memClkTrue),
        .memClkComp(memClkComp));

    assign mon = {fsBusClk, hsBusClk, memClkTrue, memCoreClock,
                  memDoubleClock, memBusClock, fsClock12m, fsClock48m,
                  hsPhyRefClk};

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chkc(input int i, input int e);
        chk((cnt[i] >= e - 1 && cnt[i] <= e + 1) ? e : cnt[i], e);
    endtask

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Edge counters, complement pair and timeout
    // --------------------------------------------------------------
    always @(posedge clk_sys) begin
        monPrev <= mon;
        for (int i = 0; i < 9; i++) begin
            if (mon[i] === 1'b1 && monPrev[i] === 1'b0) cnt[i]++;
        end
        if (rst_n) chk(memClkComp, {31'h0, ~memClkTrue});
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop;
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk_sys);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                    pwdata: d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (apbRsp.pready !== 1'b1);
        r = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic cfg(input logic [4:0] c);
        logic [31:0] r;
        logic        e;
        apb(1'b1, OFS_CTRL, {27'h0, c}, r, e);
        apb(1'b0, OFS_CTRL, 32'h0, r, e);
        chk(r, {27'h0, c});
        repeat (20) @(posedge clk_sys);
        cnt = '{default: 0};
        repeat (N) @(posedge clk_sys);
        #1;
        chkc(0, c[0] ? N / 6 : N / 2);
        chkc(1, c[1] ? N / 2 : N / 4);
        chkc(2, c[1] ? N / 8 : N / 16);
        chkc(3, c[4] ? 0 : N / 8);
        chkc(4, c[3] ? N / 6 : N / 2);
        chkc(5, c[3] ? N / 12 : N / 4);
        chkc(6, c[3] ? N / 12 : N / 4);
        chkc(7, N / 4);
        chkc(8, N / 8);
        chk(hsPhyKeep48, {31'h0, c[2] | ~usbSuspend});
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        chk(r, {26'h0, c[2] | ~usbSuspend, usbSuspend, 1'b0, c[3], c[1],
                c[0]});
        $display("test cfg %h done", c);
    endtask

    initial begin : main
        logic [31:0] r;
        logic        e;
        rst_n = 1'b0;
        ce = 1'b1;
        usbSuspend = 1'b0;
        apbReq = '0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b0, OFS_REFFREQ, 32'h0, r, e);
        chk(r, {28'h0, REFFREQ_RST});
        apb(1'b1, 12'h00C, 32'h1F, r, e);
        chk(e, 1'b1);
        apb(1'b0, 12'h00C, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test regs done");
        for (int i = 0; i <= 9; i++) begin
            apb(1'b1, OFS_REFFREQ, i, r, e);
            apb(1'b0, OFS_REFFREQ, 32'h0, r, e);
            chk(r, (i <= 8) ? i : 8);
            chk(hsPhyRefFreq, (i <= 8) ? i : 8);
        end
        $display("test reffreq done");
        cfg(5'h04);
        cfg(5'h1B);
        usbSuspend <= 1'b1;
        cfg(5'h0C);
        cfg(5'h12);
        // Clock enable low must freeze every clock output
        ce <= 1'b0;
        @(posedge clk_sys);
        #1;
        r = {23'h0, mon};
        repeat (8) @(posedge clk_sys);
        #1;
        chk({23'h0, mon}, r);
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("test ce done");
        report_and_stop;
    end
endmodule // testbench
